// ---- smr_pkg.sv ----
/*
 Package for the stop-mode recovery block: register offsets, field
 positions, reset values, source codes and timing constants.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package smr_pkg;

   // ----------------------------------------------------------------
   // Register map (bank F, byte offsets as printed)
   // ----------------------------------------------------------------
   localparam logic [7:0] SMR_OFF_CTRL = 8'h0B;
   localparam logic [7:0] SMR_OFF_CTRL2 = 8'h0D;
   localparam logic [3:0] SMR_BANK_F = 4'hF;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SMR_BIT_FLAG = 7;
   localparam int SMR_BIT_LEVEL = 6;
   localparam int SMR_BIT_DELAY = 5;
   localparam int SMR_SRC_LO = 2;
   localparam int SMR_SRC_HI = 4;
   localparam int SMR_BIT_DIV = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] SMR_SRC_RST = 3'h0;
   localparam logic SMR_LEVEL_RST = 1'b0;
   localparam logic SMR_DELAY_RST = 1'b0;
   localparam logic SMR_DIV_RST = 1'b0;

   // ----------------------------------------------------------------
   // Source codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SMR_SRC_POR = 3'h0,
      SMR_SRC_NAND_P2L = 3'h1,
      SMR_SRC_NAND_P2 = 3'h2,
      SMR_SRC_NOR_P3 = 3'h3,
      SMR_SRC_NAND_P3 = 3'h4,
      SMR_SRC_NOR_P3P0 = 3'h5,
      SMR_SRC_NAND_P3P0 = 3'h6,
      SMR_SRC_NAND_P3P2 = 3'h7
   } smr_src_t;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SMR_CLK_MHZ = 40;
   localparam int SMR_RST_DELAY_US = 50;
   localparam int SMR_RST_DELAY_CYC = SMR_RST_DELAY_US * SMR_CLK_MHZ;
   localparam logic [3:0] SMR_DIV_LAST = 4'hF;

endpackage

// ---- smr_cfg_if.sv ----
/*
 Interface carrying one recovery source configuration from the top to
 the wake-gate evaluator.
 Assumes both ends run on sys_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
interface smr_cfg_if;
   logic [2:0] src;
   logic level;
   logic wake;
   modport ctl (output src, output level, input wake);
   modport gate (input src, input level, output wake);
endinterface
`default_nettype wire

// ---- smr_gate.sv ----
/*
 Evaluates one recovery source: pin group gate, output-pin masking and
 the level XOR stage.
 Assumes pins and direction bits are already synchronised.
*/
`timescale 1ns/100ps
`default_nettype none
module smr_gate (
   smr_cfg_if.gate cfg,
   input wire logic [7:0] p0_i,
   input wire logic [7:0] p2_i,
   input wire logic [3:0] p3_i,
   input wire logic [7:0] p0_out_i,
   input wire logic [7:0] p2_out_i
);
   logic [4:0] grp;
   logic [4:0] use_m;
   logic [7:0] g8;
   logic [7:0] m8;
   logic any_in;
   logic gate_out;
   logic is_nor;

   // ----------------------------------------------------------------
   // Pin set selection
   // ----------------------------------------------------------------
   always_comb begin
      g8 = 8'hFF;
      m8 = 8'h00;
      is_nor = 1'b0;
      grp = {p3_i[3:1], p0_i[0], p0_i[7]};
      use_m = {3'h7, ~p0_out_i[0], ~p0_out_i[7]};
      case (cfg.src)
         smr_pkg::SMR_SRC_NAND_P2L: begin
            g8 = p2_i;
            m8 = {4'h0, ~p2_out_i[3:0]};
         end
         smr_pkg::SMR_SRC_NAND_P2: begin
            g8 = p2_i;
            m8 = ~p2_out_i;
         end
         smr_pkg::SMR_SRC_NOR_P3: begin
            g8 = {5'h1F, p3_i[3:1]};
            m8 = 8'h07;
            is_nor = 1'b1;
         end
         smr_pkg::SMR_SRC_NAND_P3: begin
            g8 = {5'h1F, p3_i[3:1]};
            m8 = 8'h07;
         end
         smr_pkg::SMR_SRC_NOR_P3P0: begin
            g8 = {3'h7, grp};
            m8 = {3'h0, use_m};
            is_nor = 1'b1;
         end
         smr_pkg::SMR_SRC_NAND_P3P0: begin
            g8 = {3'h7, grp};
            m8 = {3'h0, use_m};
         end
         smr_pkg::SMR_SRC_NAND_P3P2: begin
            g8 = {2'h3, p3_i[3:1], p2_i[2:0]};
            m8 = {2'h0, 3'h7, ~p2_out_i[2:0]};
         end
         default: begin
            g8 = 8'hFF;
            m8 = 8'h00;
         end
      endcase
      any_in = |m8;
      if (is_nor) begin
         gate_out = ~|(g8 & m8);
      end else begin
         gate_out = ~&(g8 | ~m8);
      end
   end

   // Level XOR: low level wanted when level bit is 1
   assign cfg.wake = any_in & (gate_out ^ ~cfg.level);

endmodule
`default_nettype wire

// ---- smr_top.sv ----
/*
 Stop-mode recovery block: two bank F control registers, wake source
 selection, recovery flag, post-recovery reset delay and clock divide.
 Assumes a simple one-cycle register port on sys_clk_i and port pins
 arriving asynchronously.
*/
`timescale 1ns/100ps
`default_nettype none
module smr_top #(
   parameter int RST_DELAY_CYC = smr_pkg::SMR_RST_DELAY_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] bank_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic stop_i,
   input wire logic [7:0] p0_i,
   input wire logic [7:0] p2_i,
   input wire logic [3:0] p3_i,
   input wire logic [7:0] p0_out_i,
   input wire logic [7:0] p2_out_i,
   output logic wake_o,
   output logic recovery_rst_o,
   output logic p1_dir_default_o,
   output logic clk_en_o,
   output logic timer_clock_en_o
);
   localparam int CW = $clog2(RST_DELAY_CYC + 1);

   logic [7:0] p0_s1_q, p0_s2_q, p2_s1_q, p2_s2_q;
   logic [3:0] p3_s1_q, p3_s2_q;
   logic [2:0] src1_q, src2_q;
   logic lvl1_q, lvl2_q, delay_q, div_q, flag_q;
   logic [CW-1:0] dcnt_q;
   logic [3:0] div_cnt_q;
   logic wake_any;
   logic sel1, sel2;

   smr_cfg_if cfg1 ();
   smr_cfg_if cfg2 ();

   typedef enum logic [2:0] {
      SMR_ST_RUN = 3'h1,
      SMR_ST_STOP = 3'h2,
      SMR_ST_DELAY = 3'h4
   } smr_state_t;
   smr_state_t st_q;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p0_s1_q <= 8'hFF;
         p0_s2_q <= 8'hFF;
         p2_s1_q <= 8'hFF;
         p2_s2_q <= 8'hFF;
         p3_s1_q <= 4'hF;
         p3_s2_q <= 4'hF;
      end else begin
         p0_s1_q <= p0_i;
         p0_s2_q <= p0_s1_q;
         p2_s1_q <= p2_i;
         p2_s2_q <= p2_s1_q;
         p3_s1_q <= p3_i;
         p3_s2_q <= p3_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   always_comb begin
      sel1 = 1'b0;
      sel2 = 1'b0;
      if (bank_i == smr_pkg::SMR_BANK_F &&
          addr_i == smr_pkg::SMR_OFF_CTRL) begin
         sel1 = 1'b1;
      end else if (bank_i == smr_pkg::SMR_BANK_F &&
                   addr_i == smr_pkg::SMR_OFF_CTRL2) begin
         sel2 = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Primary control register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lvl1_q <= smr_pkg::SMR_LEVEL_RST;
         delay_q <= smr_pkg::SMR_DELAY_RST;
         src1_q <= smr_pkg::SMR_SRC_RST;
         div_q <= smr_pkg::SMR_DIV_RST;
      end else if (wr_i && sel1) begin
         lvl1_q <= wdata_i[smr_pkg::SMR_BIT_LEVEL];
         delay_q <= wdata_i[smr_pkg::SMR_BIT_DELAY];
         src1_q <= wdata_i[smr_pkg::SMR_SRC_HI:smr_pkg::SMR_SRC_LO];
         div_q <= wdata_i[smr_pkg::SMR_BIT_DIV];
      end
   end

   // ----------------------------------------------------------------
   // Secondary control register, untouched by recovery
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lvl2_q <= smr_pkg::SMR_LEVEL_RST;
         src2_q <= smr_pkg::SMR_SRC_RST;
      end else if (wr_i && sel2) begin
         lvl2_q <= wdata_i[smr_pkg::SMR_BIT_LEVEL];
         src2_q <= wdata_i[smr_pkg::SMR_SRC_HI:smr_pkg::SMR_SRC_LO];
      end
   end

   // ----------------------------------------------------------------
   // Read port: only the flag is visible
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i && sel1) begin
         rdata_o <= {flag_q, 7'h00};
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Source evaluators
   // ----------------------------------------------------------------
   assign cfg1.src = src1_q;
   assign cfg1.level = lvl1_q;
   assign cfg2.src = src2_q;
   assign cfg2.level = lvl2_q;

   smr_gate u_gate1 (
      .cfg(cfg1),
      .p0_i(p0_s2_q),
      .p2_i(p2_s2_q),
      .p3_i(p3_s2_q),
      .p0_out_i(p0_out_i),
      .p2_out_i(p2_out_i)
   );

   smr_gate u_gate2 (
      .cfg(cfg2),
      .p0_i(p0_s2_q),
      .p2_i(p2_s2_q),
      .p3_i(p3_s2_q),
      .p0_out_i(p0_out_i),
      .p2_out_i(p2_out_i)
   );

   assign wake_any = cfg1.wake | cfg2.wake;

   // ----------------------------------------------------------------
   // Stop / recovery sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= SMR_ST_RUN;
         dcnt_q <= '0;
      end else begin
         case (st_q)
            SMR_ST_RUN: begin
               if (stop_i) begin
                  st_q <= SMR_ST_STOP;
               end
            end
            SMR_ST_STOP: begin
               if (wake_any) begin
                  if (delay_q) begin
                     st_q <= SMR_ST_DELAY;
                     dcnt_q <= CW'(RST_DELAY_CYC - 1);
                  end else begin
                     st_q <= SMR_ST_RUN;
                  end
               end
            end
            SMR_ST_DELAY: begin
               if (dcnt_q == '0) begin
                  st_q <= SMR_ST_RUN;
               end else begin
                  dcnt_q <= dcnt_q - 1'b1;
               end
            end
            default: begin
               st_q <= SMR_ST_RUN;
            end
         endcase
      end
   end

   // Flag only cleared by power-on reset
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_q <= 1'b0;
      end else if (st_q == SMR_ST_STOP && wake_any) begin
         flag_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_o <= 1'b0;
         p1_dir_default_o <= 1'b0;
      end else begin
         wake_o <= (st_q == SMR_ST_STOP) && wake_any;
         p1_dir_default_o <= (st_q == SMR_ST_STOP) && wake_any;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         recovery_rst_o <= 1'b0;
      end else begin
         recovery_rst_o <= (st_q == SMR_ST_STOP && wake_any && delay_q) ||
                           (st_q == SMR_ST_DELAY && dcnt_q != '0);
      end
   end

   // ----------------------------------------------------------------
   // Divide-by-16 clock enables
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt_q <= 4'h0;
      end else begin
         div_cnt_q <= div_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_en_o <= 1'b0;
         timer_clock_en_o <= 1'b0;
      end else begin
         clk_en_o <= (st_q != SMR_ST_STOP) &&
                     (!div_q || div_cnt_q == smr_pkg::SMR_DIV_LAST);
         timer_clock_en_o <= (st_q != SMR_ST_STOP) &&
                     (!div_q || div_cnt_q == smr_pkg::SMR_DIV_LAST);
      end
   end

endmodule
`default_nettype wire

// ---- smr_chk_sva.sv ----
/*
 Checker for the stop-mode recovery top: read data, flag, wake pulse,
 reset delay and clock enables.
 Assumes it is bound to smr_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module smr_chk_sva #(
   parameter int RST_DELAY_CYC = smr_pkg::SMR_RST_DELAY_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] bank_i,
   input wire logic [7:0] addr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic wake_o,
   input wire logic recovery_rst_o,
   input wire logic p1_dir_default_o,
   input wire logic clk_en_o,
   input wire logic timer_clock_en_o
);
   default clocking dcb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   logic rd0b_q;
   logic seen_q;
   int dly_q;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd0b_q <= 1'b0;
         seen_q <= 1'b0;
         dly_q <= 0;
      end else begin
         rd0b_q <= rd_i && bank_i == 4'hF && addr_i == 8'h0B;
         seen_q <= seen_q | wake_o;
         dly_q <= recovery_rst_o ? dly_q + 1 : 0;
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_RDATA_IDLE: assert property (!rd0b_q |-> rdata_o == 8'h00)
      else $error("read data not zero outside a primary read");
   AST_RDATA_LOW: assert property (rd0b_q |-> rdata_o[6:0] == 7'h00)
      else $error("write-only bits visible on read");
   AST_FLAG: assert property (rd0b_q |-> rdata_o[7] == seen_q)
      else $error("recovery flag does not match past wake events");
   AST_WAKE_PULSE: assert property (wake_o |=> !wake_o)
      else $error("wake pulse longer than one cycle");
   AST_P1_DIR: assert property (wake_o |-> p1_dir_default_o)
      else $error("port 1 direction not restored on wake");
   AST_P1_ONLY: assert property ($rose(p1_dir_default_o) |-> wake_o)
      else $error("port 1 direction pulse without wake");
   AST_DLY_START: assert property ($rose(recovery_rst_o) |-> wake_o)
      else $error("reset delay started without wake");
   AST_DLY_LEN: assert property (dly_q <= RST_DELAY_CYC)
      else $error("reset delay too long");
   AST_TIMER_CLK: assert property (clk_en_o == timer_clock_en_o)
      else $error("timer clock enable differs from system enable");
   COV_WAKE_DLY: cover property (wake_o && recovery_rst_o);
   COV_FLAG_RD: cover property (rd0b_q && rdata_o[7]);
   COV_CLK_GAP: cover property (clk_en_o ##1 !clk_en_o [*8]);
endmodule
`default_nettype wire

// ---- smr_pin_model.sv ----
/*
 Port pin model: pin levels and per-pin output configuration.
 Assumes it is driven through its tasks on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module smr_pin_model (
   input wire logic sys_clk_i,
   output logic [7:0] p0_o,
   output logic [7:0] p2_o,
   output logic [3:0] p3_o,
   output logic [7:0] p0_out_o,
   output logic [7:0] p2_out_o
);
   initial begin
      p0_o = 8'hFF;
      p2_o = 8'hFF;
      p3_o = 4'hF;
      p0_out_o = 8'h00;
      p2_out_o = 8'h00;
   end
   task automatic drive(input logic [7:0] a, input logic [7:0] b,
      input logic [3:0] c);
      @(posedge sys_clk_i);
      p0_o <= a;
      p2_o <= b;
      p3_o <= c;
   endtask
   task automatic drive_out(input logic [7:0] a, input logic [7:0] b);
      @(posedge sys_clk_i);
      p0_out_o <= a;
      p2_out_o <= b;
   endtask
endmodule
`default_nettype wire

// ---- stop_mode_recovery_bench.sv ----
/*
 Testbench for the stop-mode recovery top: registers, wake sources,
 masking, reset delay and clock divide.
 Assumes smr_top, smr_pin_model and smr_chk_sva are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module stop_mode_recovery_bench;
   localparam int DLY = 4;
   logic sys_clk_i, rst_n_i, wr_i, rd_i, stop_i;
   logic [3:0] bank_i, p3_i;
   logic [7:0] addr_i, wdata_i, rdata_o, p0_i, p2_i, p0_out_i, p2_out_i;
   logic wake_o, recovery_rst_o, p1_dir_default_o, clk_en_o, timer_clock_en;
   int num_errors, n_compared;
   smr_top #(.RST_DELAY_CYC(DLY)) smr_top_inst (.sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i), .bank_i(bank_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .stop_i(stop_i), .p0_i(p0_i), .p2_i(p2_i), .p3_i(p3_i),
      .p0_out_i(p0_out_i), .p2_out_i(p2_out_i), .wake_o(wake_o),
      .recovery_rst_o(recovery_rst_o),
      .p1_dir_default_o(p1_dir_default_o), .clk_en_o(clk_en_o),
      .timer_clock_en_o(timer_clock_en));
   smr_pin_model smr_pin_model_inst (.sys_clk_i(sys_clk_i), .p0_o(p0_i),
      .p2_o(p2_i), .p3_o(p3_i), .p0_out_o(p0_out_i), .p2_out_o(p2_out_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic do_reset;
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      bank_i <= 4'hF;
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] b, input logic [7:0] a,
      input logic [7:0] e);
      @(posedge sys_clk_i);
      bank_i <= b;
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 chk("rdata_o", e, rdata_o);
   endtask
   // ----------------------------------------------------------------
   // One recovery attempt; sec of FF leaves the second register alone
   // ----------------------------------------------------------------
   task automatic run_case(input logic [7:0] prim, input logic [7:0] sec,
      input logic hi, input logic [7:0] m0, input logic [7:0] m2,
      input logic [3:0] m3, input logic st, input logic ex);
      logic [7:0] i0;
      logic hit;
      i0 = {8{hi}};
      hit = 1'b0;
      wr(8'h0B, prim);
      if (sec != 8'hFF) wr(8'h0D, sec);
      smr_pin_model_inst.drive(i0, i0, i0[3:0]);
      repeat (4) @(posedge sys_clk_i);
      if (st) begin
         @(posedge sys_clk_i);
         stop_i <= 1'b1;
         @(posedge sys_clk_i);
         stop_i <= 1'b0;
      end
      smr_pin_model_inst.drive(i0 ^ m0, i0 ^ m2, i0[3:0] ^ m3);
      for (int n = 0; n < 10 && !hit; n++) begin
         @(posedge sys_clk_i);
         #1 hit = (wake_o === 1'b1);
      end
      chk("wake_o", {7'h00, ex}, {7'h00, hit});
      if (hit) chk("p1_dir", 8'h01, {7'h00, p1_dir_default_o});
      if (hit) chk("rst_dly", {7'h00, prim[5]}, {7'h00, recovery_rst_o});
      repeat (DLY + 3) @(posedge sys_clk_i);
      #1 chk("rst_dly_end", 8'h00, {7'h00, recovery_rst_o});
      smr_pin_model_inst.drive(i0, i0, i0[3:0]);
   endtask
   task automatic t_div(input logic [7:0] v, input logic [7:0] e);
      logic [7:0] cnt;
      logic [7:0] tcnt;
      cnt = 8'h00;
      tcnt = 8'h00;
      wr(8'h0B, v);
      repeat (20) @(posedge sys_clk_i);
      repeat (32) begin
         @(posedge sys_clk_i);
         #1 if (clk_en_o === 1'b1) cnt++;
         if (timer_clock_en === 1'b1) tcnt++;
      end
      chk("clk_en_count", e, cnt);
      chk("timer_clock_en_count", e, tcnt);
   endtask
   task automatic report_and_stop;
      if (num_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      num_errors = 0;
      n_compared = 0;
      rst_n_i = 1'b0;
      {wr_i, rd_i, stop_i} = 3'h0;
      bank_i = 4'h0;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      do_reset();
      rd_chk(4'hF, 8'h0B, 8'h00);
      wr(8'h0B, 8'hFE);
      rd_chk(4'hF, 8'h0B, 8'h00);
      rd_chk(4'hF, 8'h0D, 8'h00);
      rd_chk(4'hE, 8'h0B, 8'h00);
      rd_chk(4'hF, 8'h0C, 8'h00);
      run_case(8'h00, 8'h44, 1, 8'h00, 8'h08, 4'h0, 1, 1);
      rd_chk(4'hF, 8'h0B, 8'h80);
      run_case(8'h00, 8'h48, 1, 8'h00, 8'h80, 4'h0, 1, 1);
      run_case(8'h00, 8'h0C, 0, 8'h00, 8'h00, 4'h4, 1, 1);
      run_case(8'h00, 8'h5C, 1, 8'h00, 8'h04, 4'h0, 1, 1);
      run_case(8'h00, 8'h50, 1, 8'h00, 8'h00, 4'h8, 1, 1);
      run_case(8'h00, 8'h14, 0, 8'h80, 8'h00, 4'h0, 1, 1);
      run_case(8'h00, 8'h58, 1, 8'h01, 8'h00, 4'h0, 1, 1);
      run_case(8'h2C, 8'h00, 0, 8'h00, 8'h00, 4'h2, 1, 1);
      run_case(8'h50, 8'h00, 1, 8'h00, 8'h00, 4'h2, 1, 1);
      run_case(8'h00, 8'h44, 1, 8'h00, 8'h02, 4'h0, 1, 1);
      run_case(8'h00, 8'hFF, 1, 8'h00, 8'h02, 4'h0, 1, 1);
      run_case(8'h00, 8'hFF, 1, 8'h00, 8'h02, 4'h0, 0, 0);
      t_div(8'h01, 8'h02);
      t_div(8'h00, 8'h20);
      run_case(8'h00, 8'h40, 1, 8'hFF, 8'hFF, 4'hF, 1, 0);
      do_reset();
      smr_pin_model_inst.drive_out(8'h00, 8'h01);
      run_case(8'h00, 8'h44, 1, 8'h00, 8'h01, 4'h0, 1, 0);
      do_reset();
      smr_pin_model_inst.drive_out(8'h80, 8'h00);
      run_case(8'h00, 8'h14, 0, 8'h80, 8'h00, 4'h0, 1, 0);
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      num_errors++;
      report_and_stop();
   end
endmodule
bind smr_top smr_chk_sva #(.RST_DELAY_CYC(RST_DELAY_CYC)) smr_chk_sva_inst (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bank_i(bank_i),
   .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wake_o(wake_o),
   .recovery_rst_o(recovery_rst_o), .p1_dir_default_o(p1_dir_default_o),
   .clk_en_o(clk_en_o), .timer_clock_en_o(timer_clock_en_o));
`default_nettype wire
